// [design/onoff_pkg.sv]
// onoff_pkg: command codes, field positions, reset values and carriers
// assumes a pmbus front end that delivers one decoded transaction per pulse
package onoff_pkg;
   // command codes
   localparam logic [7:0] CMD_PAGE = 8'h00;
   localparam logic [7:0] CMD_OPERATION = 8'h01;
   localparam logic [7:0] CMD_ONOFF_CFG = 8'h02;
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
   // supply_onoff_config field positions
   localparam int CFG_OR_SEL = 5;
   localparam int CFG_USE_CMDS = 4;
   localparam int CFG_OP_EN = 3;
   localparam int CFG_PIN_EN = 2;
   localparam int CFG_PIN_POL = 1;
   localparam int CFG_FAST_OFF = 0;
   localparam logic [7:0] CFG_WMASK = 8'h3F;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // write_lock_level values
   localparam logic [7:0] WP_ALL = 8'h80;
   localparam logic [7:0] WP_OP = 8'h40;
   localparam logic [7:0] WP_CFG = 8'h20;
   localparam logic [7:0] WP_NONE = 8'h00;
   localparam logic [7:0] WP_RESET = 8'h00;
   // operation data bytes
   localparam logic [7:0] OP_OFF_BOTH = 8'h00;
   localparam logic [7:0] OP_OFF_SEQ0 = 8'h01;
   localparam logic [7:0] OP_OFF_SEQ1 = 8'h02;
   localparam logic [7:0] OP_SOFT_BOTH = 8'h40;
   localparam logic [7:0] OP_SOFT_SEQ0 = 8'h41;
   localparam logic [7:0] OP_SOFT_SEQ1 = 8'h42;
   localparam logic [7:0] OP_ON_BOTH = 8'h80;
   localparam logic [7:0] OP_ON_SEQ0 = 8'h81;
   localparam logic [7:0] OP_ON_SEQ1 = 8'h82;
   localparam logic [7:0] OP_MLOW_IGN = 8'h94;
   localparam logic [7:0] OP_MLOW_ACT = 8'h98;
   localparam logic [7:0] OP_MHIGH_IGN = 8'hA4;
   localparam logic [7:0] OP_MHIGH_ACT = 8'hA8;
   // sizes
   localparam int NFAULT = 8;
   localparam int NSEQ = 2;
   localparam int RAM_DEPTH = 256;
   // one decoded host transaction
   typedef struct packed {
      logic valid;
      logic write;
      logic has_data;
      logic [7:0] code;
      logic [7:0] data;
   } cmd_s;
   // supply enable outputs and how the last turn-off was done
   typedef struct packed {
      logic [1:0] enable;
      logic [1:0] soft_off;
   } supply_s;
endpackage

// [design/pin_sync.sv]
// pin_sync: two-flop synchroniser for pins that arrive from outside ref_clk
// assumes each bit is an independent level
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   // first stage feeds only the second
   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule

// [design/work_ram.sv]
// work_ram: volatile working copy of the command parameters
// assumes one write or one read per cycle; read data come from a register
`timescale 1ns/10ps
module work_ram (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic we,
   input wire logic re,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic rvalid
);
   logic [7:0] mem [onoff_pkg::RAM_DEPTH];
   logic [7:0] next_rdata;
   logic next_rvalid;

   // read path
   always_comb begin
      next_rdata = re ? mem[addr] : rdata;
      next_rvalid = re;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rdata <= next_rdata;
         rvalid <= next_rvalid;
      end
   end

   // storage has no reset
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule

// [design/supply_onoff_and_write_guard.sv]
// supply_onoff_and_write_guard: on/off combining, fault clearing, write lock
// assumes a pmbus engine hands over decoded transactions on ref_clk and
// fault levels come from monitors on the same clock
`timescale 1ns/10ps
// Function
// - with pin and command both used, bit 5 picks and (clear) or or (set).
// - and mode: on needs both requesting on; either requesting off turns off.
// - bit 4 clear: supplies on as soon as bias is present, pins ignored.
// - bit 4 set: only enabled pins and/or enabled operation decide on/off.
// - bit 3 clear ignores the on/off part of operation; set honours it.
// - bit 1 clear: low pin means on; set: high pin means on.
// - pin off uses turn-off delays if bit 0 clear, immediate off if set.
// - one configuration byte governs both control pins identically.
// - clear faults drops all latched status bits and releases alert.
// - clear faults also drops the power-on and watchdog flags.
// - clear faults never changes the supply enables.
// - persisting fault sets its status again after clear, without alert.
// - after clear, alert returns only for a newly detected fault or an unlisted operation byte.
// - clear faults is a write with no data byte; it is not read.
// - reads of every command are allowed at any lock level.
// - 80h locks all but lock; 40h admits operation, page; 20h adds config. Clear faults is still taken at every lock level.
// - lock level 00h allows all writes and is the reset level.
// - a locked-out write is dropped silently with no flag or alert.
// - accepted writes land only in the volatile working copy.
// - operation 00h turns off at once; 40h-42h power down with delays.
// - unlisted operation byte sets the communication error and alert.
module supply_onoff_and_write_guard (
   input wire logic ref_clk,
   input wire logic rst,
   input wire onoff_pkg::cmd_s cmd,
   input wire logic first_supply_control_pin,
   input wire logic second_supply_control_pin,
   input wire logic bias_present,
   input wire logic [onoff_pkg::NFAULT-1:0] fault_now,
   input wire logic watchdog_event,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output onoff_pkg::supply_s supply_enable_output,
   output logic [onoff_pkg::NFAULT-1:0] status_latched,
   output logic comm_error,
   output logic por_flag,
   output logic watchdog_flag,
   output logic alert_n
);
   logic [2:0] pins_s;
   logic [1:0] pin_s;
   logic bias_s;
   logic [7:0] cfg;
   logic [7:0] wp;
   logic [7:0] page;
   logic [1:0] op_on;
   logic [1:0] op_imm;
   logic [7:0] next_cfg;
   logic [7:0] next_wp;
   logic [7:0] next_page;
   logic [1:0] next_op_on;
   logic [1:0] next_op_imm;
   logic allowed;
   logic write_ok;
   logic op_bad;
   logic clear;
   logic ram_we;
   logic [7:0] ram_wdata;
   logic [3:0] dec;
   logic dec_valid;
   logic [1:0] pin_on;
   logic [1:0] want;
   onoff_pkg::supply_s next_sup;
   logic [onoff_pkg::NFAULT-1:0] fault_prev;
   logic [onoff_pkg::NFAULT-1:0] next_status;
   logic new_evt;
   logic next_alert_n;
   logic next_cml;
   logic next_por;
   logic next_wdog;
   logic or_sel;
   logic use_cmds;
   logic op_en;
   logic pin_en;
   logic fast_off;

   // pins and bias come from outside the clock domain
   pin_sync #(.W(3)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({bias_present, second_supply_control_pin, first_supply_control_pin}),
      .q(pins_s)
   );
   assign pin_s = pins_s[1:0];
   assign bias_s = pins_s[2];

   // operation byte decode: {on, immediate, seq1, seq0}
   always_comb begin
      dec_valid = 1'b1;
      unique case (cmd.data)
         onoff_pkg::OP_OFF_BOTH: dec = 4'h7;
         onoff_pkg::OP_OFF_SEQ0: dec = 4'h5;
         onoff_pkg::OP_OFF_SEQ1: dec = 4'h6;
         onoff_pkg::OP_SOFT_BOTH: dec = 4'h3;
         onoff_pkg::OP_SOFT_SEQ0: dec = 4'h1;
         onoff_pkg::OP_SOFT_SEQ1: dec = 4'h2;
         onoff_pkg::OP_ON_SEQ0: dec = 4'h9;
         onoff_pkg::OP_ON_SEQ1: dec = 4'hA;
         onoff_pkg::OP_ON_BOTH, onoff_pkg::OP_MLOW_IGN, onoff_pkg::OP_MLOW_ACT,
         onoff_pkg::OP_MHIGH_IGN, onoff_pkg::OP_MHIGH_ACT: dec = 4'hB;
         default: begin
            dec = 4'h0;
            dec_valid = 1'b0;
         end
      endcase
   end

   // write lock admission; reads are never gated
   always_comb begin
      unique case (wp)
         onoff_pkg::WP_ALL: allowed = (cmd.code == onoff_pkg::CMD_WRITE_LOCK);
         onoff_pkg::WP_OP: allowed = (cmd.code == onoff_pkg::CMD_WRITE_LOCK) ||
            (cmd.code == onoff_pkg::CMD_OPERATION) || (cmd.code == onoff_pkg::CMD_PAGE);
         onoff_pkg::WP_CFG: allowed = (cmd.code == onoff_pkg::CMD_WRITE_LOCK) ||
            (cmd.code == onoff_pkg::CMD_OPERATION) || (cmd.code == onoff_pkg::CMD_PAGE) ||
            (cmd.code == onoff_pkg::CMD_ONOFF_CFG);
         default: allowed = 1'b1;
      endcase
   end

   // blocked writes vanish without any flag
   assign write_ok = cmd.valid && cmd.write && cmd.has_data && allowed;
   assign op_bad = write_ok && (cmd.code == onoff_pkg::CMD_OPERATION) && !dec_valid;
   assign clear = cmd.valid && cmd.write && !cmd.has_data &&
      (cmd.code == onoff_pkg::CMD_CLEAR_FAULTS);

   // command registers
   always_comb begin
      next_cfg = cfg;
      next_wp = wp;
      next_page = page;
      next_op_on = op_on;
      next_op_imm = op_imm;
      if (write_ok) begin
         unique case (cmd.code)
            onoff_pkg::CMD_ONOFF_CFG: next_cfg = cmd.data & onoff_pkg::CFG_WMASK;
            onoff_pkg::CMD_PAGE: next_page = cmd.data;
            onoff_pkg::CMD_WRITE_LOCK: begin
               if (cmd.data == onoff_pkg::WP_ALL || cmd.data == onoff_pkg::WP_OP ||
                   cmd.data == onoff_pkg::WP_CFG || cmd.data == onoff_pkg::WP_NONE) begin
                  next_wp = cmd.data;
               end
            end
            onoff_pkg::CMD_OPERATION: begin
               for (int i = 0; i < onoff_pkg::NSEQ; i++) begin
                  if (dec[i]) begin
                     next_op_on[i] = dec[3];
                     next_op_imm[i] = dec[2];
                  end
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg <= onoff_pkg::CFG_RESET;
         wp <= onoff_pkg::WP_RESET;
         page <= 8'h00;
         op_on <= 2'b00;
         op_imm <= 2'b00;
      end else begin
         cfg <= next_cfg;
         wp <= next_wp;
         page <= next_page;
         op_on <= next_op_on;
         op_imm <= next_op_imm;
      end
   end

   // accepted writes go to the working copy only; flash is never touched
   // an ignored lock value is not stored either, so it never reads back
   assign ram_we = write_ok && !op_bad &&
      !(cmd.code == onoff_pkg::CMD_WRITE_LOCK && next_wp != cmd.data);
   assign ram_wdata = (cmd.code == onoff_pkg::CMD_ONOFF_CFG) ?
      (cmd.data & onoff_pkg::CFG_WMASK) : cmd.data;

   work_ram u_ram (
      .ref_clk(ref_clk),
      .rst(rst),
      .we(ram_we),
      .re(cmd.valid && !cmd.write && cmd.code != onoff_pkg::CMD_CLEAR_FAULTS),
      .addr(cmd.code),
      .wdata(ram_wdata),
      .rdata(rd_data),
      .rvalid(rd_valid)
   );

   // on/off decision; the same byte serves both pins
   always_comb begin
      next_sup = supply_enable_output;
      for (int i = 0; i < onoff_pkg::NSEQ; i++) begin
         pin_on[i] = cfg[onoff_pkg::CFG_PIN_POL] ? pin_s[i] : !pin_s[i];
         if (!cfg[onoff_pkg::CFG_USE_CMDS]) begin
            want[i] = bias_s;
         end else if (cfg[onoff_pkg::CFG_OP_EN] && cfg[onoff_pkg::CFG_PIN_EN]) begin
            want[i] = cfg[onoff_pkg::CFG_OR_SEL] ? (op_on[i] || pin_on[i]) :
               (op_on[i] && pin_on[i]);
         end else if (cfg[onoff_pkg::CFG_OP_EN]) begin
            want[i] = op_on[i];
         end else if (cfg[onoff_pkg::CFG_PIN_EN]) begin
            want[i] = pin_on[i];
         end else begin
            want[i] = 1'b0;
         end
         next_sup.enable[i] = want[i];
         if (supply_enable_output.enable[i] && !want[i]) begin
            if (cfg[onoff_pkg::CFG_USE_CMDS] && cfg[onoff_pkg::CFG_PIN_EN] && !pin_on[i]) begin
               next_sup.soft_off[i] = !cfg[onoff_pkg::CFG_FAST_OFF];
            end else begin
               next_sup.soft_off[i] = !op_imm[i];
            end
         end
      end
   end

   // clearing faults has no path into the enables
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         supply_enable_output <= '0;
      end else begin
         supply_enable_output <= next_sup;
      end
   end

   // latched status, flags and alert; a new event beats a same-cycle clear
   assign new_evt = |(fault_now & ~fault_prev);
   always_comb begin
      next_status = status_latched | fault_now;
      next_alert_n = alert_n && !new_evt && !op_bad;
      next_cml = comm_error || op_bad;
      next_por = por_flag;
      next_wdog = watchdog_flag || watchdog_event;
      if (clear) begin
         next_status = fault_now;
         next_alert_n = !new_evt && !op_bad;
         next_cml = op_bad;
         next_por = 1'b0;
         next_wdog = watchdog_event;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status_latched <= '0;
         fault_prev <= '0;
         alert_n <= 1'b1;
         comm_error <= 1'b0;
         por_flag <= 1'b1;
         watchdog_flag <= 1'b0;
      end else begin
         status_latched <= next_status;
         fault_prev <= fault_now;
         alert_n <= next_alert_n;
         comm_error <= next_cml;
         por_flag <= next_por;
         watchdog_flag <= next_wdog;
      end
   end

   // configuration fields as the checks below see them
   assign or_sel = cfg[onoff_pkg::CFG_OR_SEL];
   assign use_cmds = cfg[onoff_pkg::CFG_USE_CMDS];
   assign op_en = cfg[onoff_pkg::CFG_OP_EN];
   assign pin_en = cfg[onoff_pkg::CFG_PIN_EN];
   assign fast_off = cfg[onoff_pkg::CFG_FAST_OFF];

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_and_mode;
      use_cmds && op_en && pin_en && !or_sel && !op_on[0] |=> !supply_enable_output.enable[0];
   endproperty
   a_and_mode: assert property (p_and_mode) else $error("and mode left supply on");

   property p_and_on;
      use_cmds && op_en && pin_en && !or_sel && op_on[0] && pin_on[0]
         |=> supply_enable_output.enable[0];
   endproperty
   a_and_on: assert property (p_and_on) else $error("and mode failed to turn on");

   property p_bias_on;
      !use_cmds && bias_s |=> supply_enable_output.enable == 2'b11;
   endproperty
   a_bias_on: assert property (p_bias_on) else $error("bias did not enable supplies");

   property p_op_ignored;
      use_cmds && !op_en && !pin_en |=> supply_enable_output.enable == 2'b00;
   endproperty
   a_op_ignored: assert property (p_op_ignored) else $error("disabled operation acted");

   property p_pin_fast;
      use_cmds && pin_en && !op_en && fast_off && supply_enable_output.enable[0] && !pin_on[0]
         |=> !supply_enable_output.enable[0] && !supply_enable_output.soft_off[0];
   endproperty
   a_pin_fast: assert property (p_pin_fast) else $error("pin off not immediate");

   property p_clear_alert;
      clear && !new_evt && !op_bad |=> alert_n && !por_flag && status_latched == $past(fault_now);
   endproperty
   a_clear_alert: assert property (p_clear_alert) else $error("clear faults incomplete");

   property p_clear_wdog;
      clear && !watchdog_event |=> !watchdog_flag;
   endproperty
   a_clear_wdog: assert property (p_clear_wdog) else $error("watchdog flag survived");

   property p_locked;
      cmd.valid && cmd.write && wp == onoff_pkg::WP_ALL && cmd.code == onoff_pkg::CMD_ONOFF_CFG
         |=> $stable(cfg) && $stable(comm_error);
   endproperty
   a_locked: assert property (p_locked) else $error("locked write took effect");

   property p_bad_op;
      write_ok && cmd.code == onoff_pkg::CMD_OPERATION && !dec_valid |=> comm_error && !alert_n;
   endproperty
   a_bad_op: assert property (p_bad_op) else $error("bad operation not flagged");
endmodule

// [dv/host_model.sv]
// host_model: pmbus host and control pin driver facing the block
// assumes one decoded transaction per ref_clk cycle
`timescale 1ns/10ps
module host_model (
   input wire logic ref_clk,
   output onoff_pkg::cmd_s cmd,
   output logic [1:0] pins,
   output logic bias
);
   // idle lines at time zero
   initial begin
      cmd = '0;
      pins = 2'h0;
      bias = 1'b0;
   end
   // one transaction, valid for exactly one taking edge
   task automatic send(input logic wr, input logic hd, input logic [7:0] code,
                       input logic [7:0] data);
      @(posedge ref_clk);
      cmd <= '{1'b1, wr, hd, code, data};
      @(posedge ref_clk);
      cmd <= '0;
   endtask
   // clear faults is a bare code, never read back
   task automatic clear();
      send(1'b1, 1'b0, onoff_pkg::CMD_CLEAR_FAULTS, 8'h00);
   endtask
   // control pins and bias are plain levels
   task automatic lines(input logic [1:0] p, input logic b);
      @(posedge ref_clk);
      pins <= p;
      bias <= b;
   endtask
endmodule

// [dv/testbench.sv]
// testbench: reference model of on/off combining, fault clear and lock
// assumes the host_model partner and a 40 MHz ref_clk
`timescale 1ns/10ps
module testbench;
   logic ref_clk, rst, bias, watchdog_event, rd_valid, comm_error;
   logic por_flag, watchdog_flag, alert_n;
   onoff_pkg::cmd_s cmd;
   onoff_pkg::supply_s supply;
   logic [1:0] pins, opst;
   logic [7:0] fault_now, rd_data, status_latched, cfg, op, pg, wl, f, c;
   logic [7:0] ops [13];
   int num_errors, checks, seed, i;
   host_model host (.ref_clk(ref_clk), .cmd(cmd), .pins(pins), .bias(bias));
   supply_onoff_and_write_guard dut (.ref_clk(ref_clk), .rst(rst), .cmd(cmd),
      .first_supply_control_pin(pins[0]), .second_supply_control_pin(pins[1]),
      .bias_present(bias), .fault_now(fault_now), .watchdog_event(watchdog_event),
      .rd_data(rd_data), .rd_valid(rd_valid), .supply_enable_output(supply),
      .status_latched(status_latched), .comm_error(comm_error), .por_flag(por_flag),
      .watchdog_flag(watchdog_flag), .alert_n(alert_n));
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic print_verdict();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] code, input logic [7:0] data);
      host.send(1'b1, 1'b1, code, data);
   endtask
   // read answer stands for the one cycle right after the taking edge
   task automatic rd(input logic [7:0] code, input logic [7:0] exp);
      host.send(1'b0, 1'b0, code, 8'h00);
      #1;
      check("rd_valid", 8'h01, {7'h0, rd_valid});
      check("rd_data", exp, rd_data);
   endtask
   // per-sequence on request held by the operation byte
   function automatic logic [1:0] op_next(input logic [1:0] s, input logic [7:0] b);
      case (b)
         8'h00, 8'h40: return 2'h0;
         8'h01, 8'h41: return {s[1], 1'b0};
         8'h02, 8'h42: return {1'b0, s[0]};
         8'h81: return {s[1], 1'b1};
         8'h82: return {1'b1, s[0]};
         default: return 2'h3;
      endcase
   endfunction
   // expected supply enables
   function automatic logic [1:0] en_model(input logic [7:0] k, input logic [1:0] o,
                                           input logic [1:0] p, input logic b);
      logic [1:0] pr;
      pr = k[1] ? p : ~p;
      if (!k[4]) return b ? 2'h3 : 2'h0;
      if (k[3] && k[2]) return k[5] ? (o | pr) : (o & pr);
      if (k[3]) return o;
      if (k[2]) return pr;
      return 2'h0;
   endfunction
   // turn supplies off, reconfigure, then apply operation and pins
   task automatic step(input logic [7:0] k, input logic [7:0] o, input logic [1:0] p);
      host.lines(~{2{cfg[1]}}, 1'b0);
      wr(onoff_pkg::CMD_OPERATION, 8'h00);
      cyc(5);
      wr(onoff_pkg::CMD_ONOFF_CFG, k);
      wr(onoff_pkg::CMD_OPERATION, o);
      host.lines(p, 1'b1);
      cfg = k;
      opst = op_next(2'h0, o);
      cyc(6);
      check("enable", {6'h0, en_model(cfg, opst, p, 1'b1)}, {6'h0, supply.enable});
   endtask
   // hang guard
   initial begin
      #2ms;
      num_errors++;
      $display("MISMATCH timeout expected done seen hang");
      print_verdict();
   end
   // main sequence
   initial begin
      seed = 32'h1B75;
      ops = '{8'h00, 8'h01, 8'h02, 8'h40, 8'h41, 8'h42, 8'h80, 8'h81, 8'h82,
              8'h94, 8'h98, 8'hA4, 8'hA8};
      rst = 1'b1;
      fault_now = 8'h00;
      watchdog_event = 1'b0;
      cfg = 8'h00;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      cyc(1);
      check("por_flag", 8'h01, {7'h0, por_flag});
      check("alert_n", 8'h01, {7'h0, alert_n});
      for (i = 0; i < 26; i++) begin
         c = 8'($random(seed)) & 8'h3F;
         step(c, ops[i % 13], 2'($random(seed)));
      end
      // turn-off attribution by operation byte and by pin
      step(8'h18, 8'h80, 2'h0);
      wr(onoff_pkg::CMD_OPERATION, 8'h41);
      cyc(5);
      check("soft", 8'h21, {2'h0, supply.enable, 3'h0, supply.soft_off[0]});
      wr(onoff_pkg::CMD_OPERATION, 8'h02);
      cyc(5);
      check("soft1", 8'h00, {6'h0, supply.enable[1], supply.soft_off[1]});
      step(8'h16, 8'h00, 2'h3);
      host.lines(2'h2, 1'b1);
      cyc(6);
      check("pinsoft", 8'h21, {2'h0, supply.enable, 3'h0, supply.soft_off[0]});
      step(8'h17, 8'h00, 2'h3);
      host.lines(2'h1, 1'b1);
      cyc(6);
      check("pinfast", 8'h10, {2'h0, supply.enable, 3'h0, supply.soft_off[1]});
      // lock levels against cfg, operation and page writes
      step(8'h18, 8'h00, 2'h0);
      op = 8'h00;
      pg = 8'h00;
      wr(onoff_pkg::CMD_PAGE, pg);
      for (i = 0; i < 4; i++) begin
         wl = 8'h80 >> (3 - i);
         if (i == 0) wl = 8'h00;
         wr(onoff_pkg::CMD_WRITE_LOCK, wl);
         c = (i == 1) ? 8'hDC : 8'hD8;
         wr(onoff_pkg::CMD_ONOFF_CFG, c);
         wr(onoff_pkg::CMD_OPERATION, i[0] ? 8'h40 : 8'h00);
         wr(onoff_pkg::CMD_PAGE, 8'(i + 1));
         if (wl <= 8'h20) cfg = c & 8'h3F;
         if (wl != 8'h80) op = i[0] ? 8'h40 : 8'h00;
         if (wl != 8'h80) pg = 8'(i + 1);
         cyc(2);
         rd(onoff_pkg::CMD_ONOFF_CFG, cfg);
         rd(onoff_pkg::CMD_OPERATION, op);
         rd(onoff_pkg::CMD_PAGE, pg);
         rd(onoff_pkg::CMD_WRITE_LOCK, wl);
         check("quiet", 8'h01, {6'h0, comm_error, alert_n});
      end
      wr(onoff_pkg::CMD_WRITE_LOCK, 8'h00);
      wr(onoff_pkg::CMD_WRITE_LOCK, 8'h11);
      wr(onoff_pkg::CMD_ONOFF_CFG, 8'hD8);
      cfg = 8'h18;
      cyc(2);
      rd(onoff_pkg::CMD_ONOFF_CFG, 8'h18);
      rd(onoff_pkg::CMD_WRITE_LOCK, 8'h00);
      // faults, clearing and alert with supplies on
      step(8'h00, 8'h80, 2'h0);
      f = (8'($random(seed)) & 8'h7F) | 8'h01;
      @(posedge ref_clk) fault_now <= f;
      cyc(2);
      check("status", f, status_latched);
      check("alert_n", 8'h00, {7'h0, alert_n});
      host.clear();
      cyc(2);
      check("status", f, status_latched);
      check("alert_n", 8'h01, {7'h0, alert_n});
      check("por_flag", 8'h00, {7'h0, por_flag});
      check("enable", 8'h03, {6'h0, supply.enable});
      @(posedge ref_clk) fault_now <= f | 8'h80;
      cyc(2);
      check("status", f | 8'h80, status_latched);
      check("alert_n", 8'h00, {7'h0, alert_n});
      @(posedge ref_clk) fault_now <= 8'h00;
      watchdog_event <= 1'b1;
      @(posedge ref_clk) watchdog_event <= 1'b0;
      cyc(2);
      check("watchdog", 8'h01, {7'h0, watchdog_flag});
      host.clear();
      cyc(2);
      check("cleared", 8'h01, {status_latched[6:0] | {6'h0, watchdog_flag}, alert_n});
      wr(onoff_pkg::CMD_OPERATION, 8'h55);
      cyc(2);
      check("bad_op", 8'h0E, {4'h0, supply.enable, comm_error, alert_n});
      host.clear();
      cyc(2);
      check("cml_clr", 8'h01, {6'h0, comm_error, alert_n});
      print_verdict();
   end
endmodule
